// file: verilog/brt_defs.vh
// Constants for the 18-bit registered bus transceiver.
// Assumes one clock and an APB master that keeps to APB signalling.
`ifndef BRT_DEFS_VH
`define BRT_DEFS_VH

`define BRT_WIDTH          18
`define BRT_ADDR_W         12
`define BRT_DATA_W         32

`define BRT_ADDR_CTRL      12'h000
`define BRT_ADDR_STATUS    12'h004
`define BRT_ADDR_DATA_AB   12'h008
`define BRT_ADDR_DATA_BA   12'h00C

`define BRT_CTRL_HOLD_A    0
`define BRT_CTRL_HOLD_B    1
`define BRT_CTRL_RESET     2'h0

`define BRT_ST_LOADED_AB   0
`define BRT_ST_LOADED_BA   1
`define BRT_ST_DRIVE_B     2
`define BRT_ST_DRIVE_A     3
`define BRT_ST_TRANSP_AB   4
`define BRT_ST_TRANSP_BA   5

`define BRT_ZERO_DATA      32'h0000_0000
`define BRT_ZERO_BITS      18'h0_0000

`endif

// file: verilog/brt_transceiver.v
// Top of the 18-bit registered bus transceiver, all pins sampled on MCLK.
// Assumes pins come from outside the clock domain; the bench resolves
// each three-state pin from its output and output enable.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "brt_defs.vh"

module brt_transceiver (
    input  wire                       MCLK,
    input  wire                       RST_N,
    input  wire                       PSEL,
    input  wire                       PENABLE,
    input  wire                       PWRITE,
    input  wire [`BRT_ADDR_W-1:0]     PADDR,
    input  wire [`BRT_DATA_W-1:0]     PWDATA,
    output reg  [`BRT_DATA_W-1:0]     PRDATA,
    output wire                       PREADY,
    output reg                        PSLVERR,
    input  wire                       A_TO_B_OUT_ENABLE,
    input  wire                       B_TO_A_OUT_ENABLE_N,
    input  wire                       A_TO_B_LATCH_ENABLE,
    input  wire                       B_TO_A_LATCH_ENABLE,
    input  wire                       A_TO_B_CLOCK,
    input  wire                       B_TO_A_CLOCK,
    input  wire [`BRT_WIDTH-1:0]      A_IN,
    input  wire [`BRT_WIDTH-1:0]      A_DRIVEN,
    output reg  [`BRT_WIDTH-1:0]      A_OUT,
    output reg  [`BRT_WIDTH-1:0]      A_OE,
    input  wire [`BRT_WIDTH-1:0]      B_IN,
    input  wire [`BRT_WIDTH-1:0]      B_DRIVEN,
    output reg  [`BRT_WIDTH-1:0]      B_OUT,
    output reg  [`BRT_WIDTH-1:0]      B_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic looks at a bus or direction-control pin.
    reg [5:0]               ctl_s1_q;
    reg [5:0]               ctl_s2_q;
    reg [`BRT_WIDTH-1:0]    a_s1_q;
    reg [`BRT_WIDTH-1:0]    a_s2_q;
    reg [`BRT_WIDTH-1:0]    b_s1_q;
    reg [`BRT_WIDTH-1:0]    b_s2_q;
    reg [`BRT_WIDTH-1:0]    adrv_s1_q;
    reg [`BRT_WIDTH-1:0]    adrv_s2_q;
    reg [`BRT_WIDTH-1:0]    bdrv_s1_q;
    reg [`BRT_WIDTH-1:0]    bdrv_s2_q;

    always @(posedge MCLK) begin
        ctl_s1_q  <= {B_TO_A_CLOCK, A_TO_B_CLOCK, B_TO_A_LATCH_ENABLE,
                      A_TO_B_LATCH_ENABLE, B_TO_A_OUT_ENABLE_N, A_TO_B_OUT_ENABLE};
        ctl_s2_q  <= ctl_s1_q;
        a_s1_q    <= A_IN;
        a_s2_q    <= a_s1_q;
        b_s1_q    <= B_IN;
        b_s2_q    <= b_s1_q;
        adrv_s1_q <= A_DRIVEN;
        adrv_s2_q <= adrv_s1_q;
        bdrv_s1_q <= B_DRIVEN;
        bdrv_s2_q <= bdrv_s1_q;
    end

    wire oe_ab   = ctl_s2_q[0];
    wire oe_ba_n = ctl_s2_q[1];
    wire le_ab   = ctl_s2_q[2];
    wire le_ba   = ctl_s2_q[3];
    wire clk_ab  = ctl_s2_q[4];
    wire clk_ba  = ctl_s2_q[5];

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible control: bus-hold enable per port.
    reg [1:0] ctrl_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus hold: a released input bit keeps its last driven level.
    reg  [`BRT_WIDTH-1:0] a_keep_q;
    reg  [`BRT_WIDTH-1:0] b_keep_q;
    wire [`BRT_WIDTH-1:0] a_eff;
    wire [`BRT_WIDTH-1:0] b_eff;

    genvar gi;
    generate
        for (gi = 0; gi < `BRT_WIDTH; gi = gi + 1) begin : g_hold
            always @(posedge MCLK) begin
                if (adrv_s2_q[gi]) begin
                    a_keep_q[gi] <= a_s2_q[gi];
                end
                if (bdrv_s2_q[gi]) begin
                    b_keep_q[gi] <= b_s2_q[gi];
                end
            end
            assign a_eff[gi] = (ctrl_q[`BRT_CTRL_HOLD_A] && !adrv_s2_q[gi]) ? a_keep_q[gi] : a_s2_q[gi];
            assign b_eff[gi] = (ctrl_q[`BRT_CTRL_HOLD_B] && !bdrv_s2_q[gi]) ? b_keep_q[gi] : b_s2_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Clock edge detection on the synchronised direction clocks.
    reg  clk_ab_q;
    reg  clk_ba_q;
    wire rise_ab = clk_ab && !clk_ab_q;
    wire rise_ba = clk_ba && !clk_ba_q;

    always @(posedge MCLK) begin
        if (!RST_N) begin
            clk_ab_q <= 1'b1;
            clk_ba_q <= 1'b1;
        end else begin
            clk_ab_q <= clk_ab;
            clk_ba_q <= clk_ba;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage elements: one latch/flip-flop per bit, never reset.
    reg  [`BRT_WIDTH-1:0] store_ab_q;
    reg  [`BRT_WIDTH-1:0] store_ba_q;
    wire                  load_ab = le_ab || rise_ab;
    wire                  load_ba = le_ba || rise_ba;

    always @(posedge MCLK) begin
        if (load_ab) begin
            store_ab_q <= a_eff;
        end
        if (load_ba) begin
            store_ba_q <= b_eff;
        end
    end

    // Loaded flags only report whether the storage has seen data yet.
    reg loaded_ab_q;
    reg loaded_ba_q;

    always @(posedge MCLK) begin
        if (!RST_N) begin
            loaded_ab_q <= 1'b0;
            loaded_ba_q <= 1'b0;
        end else begin
            if (load_ab) begin
                loaded_ab_q <= 1'b1;
            end
            if (load_ba) begin
                loaded_ba_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage: data from flops, output enables held off during reset.
    always @(posedge MCLK) begin
        if (load_ab) begin
            B_OUT <= a_eff;
        end
        if (load_ba) begin
            A_OUT <= b_eff;
        end
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            B_OE <= `BRT_ZERO_BITS;
            A_OE <= `BRT_ZERO_BITS;
        end else begin
            B_OE <= {`BRT_WIDTH{oe_ab}};
            A_OE <= {`BRT_WIDTH{!oe_ba_n}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    wire setup  = PSEL && !PENABLE;
    wire access = PSEL && PENABLE;
    reg  mapped;

    assign PREADY = 1'b1;

    always @* begin
        case (PADDR)
            `BRT_ADDR_CTRL:    mapped = 1'b1;
            `BRT_ADDR_STATUS:  mapped = 1'b1;
            `BRT_ADDR_DATA_AB: mapped = 1'b1;
            `BRT_ADDR_DATA_BA: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            ctrl_q <= `BRT_CTRL_RESET;
        end else if (access && PWRITE && PADDR == `BRT_ADDR_CTRL) begin
            ctrl_q <= PWDATA[1:0];
        end
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            PRDATA  <= `BRT_ZERO_DATA;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PSLVERR <= !mapped;
            PRDATA  <= `BRT_ZERO_DATA;
            if (!PWRITE) begin
                case (PADDR)
                    `BRT_ADDR_CTRL: begin
                        PRDATA[1:0] <= ctrl_q;
                    end
                    `BRT_ADDR_STATUS: begin
                        PRDATA[`BRT_ST_LOADED_AB] <= loaded_ab_q;
                        PRDATA[`BRT_ST_LOADED_BA] <= loaded_ba_q;
                        PRDATA[`BRT_ST_DRIVE_B]   <= oe_ab;
                        PRDATA[`BRT_ST_DRIVE_A]   <= !oe_ba_n;
                        PRDATA[`BRT_ST_TRANSP_AB] <= le_ab;
                        PRDATA[`BRT_ST_TRANSP_BA] <= le_ba;
                    end
                    `BRT_ADDR_DATA_AB: begin
                        PRDATA[`BRT_WIDTH-1:0] <= store_ab_q;
                    end
                    `BRT_ADDR_DATA_BA: begin
                        PRDATA[`BRT_WIDTH-1:0] <= store_ba_q;
                    end
                    default: begin
                        PRDATA <= `BRT_ZERO_DATA;
                    end
                endcase
            end
        end
    end

endmodule // brt_transceiver

// file: testbench/brt_far_port.sv
// Far-side model of one 18-bit data port.
// Assumes the device's pin outputs and enables come straight from the design.
`timescale 1ns/1ps
module brt_far_port (
    input  wire        clk,
    input  wire        drive,
    input  wire [17:0] val,
    input  wire [17:0] dev_out,
    input  wire [17:0] dev_oe,
    output logic [17:0] pin,
    output wire [17:0] driven
);
    logic [17:0] last_q = 18'h0_0000;
    assign driven = {18{drive}};
    // A line that nobody drives shows a level that toggles every cycle.
    always_comb
        for (int i = 0; i < 18; i++)
            pin[i] = drive ? val[i] : dev_oe[i] ? dev_out[i] : ~last_q[i];
    always @(posedge clk)
        last_q <= pin;
endmodule // brt_far_port

// file: testbench/brt_chk.sv
// Assertions on the transceiver pin paths.
// Assumes bind into brt_transceiver; a pin reaches the outputs 3 edges later.
`timescale 1ns/1ps
module brt_chk (
    input wire        MCLK,
    input wire        RST_N,
    input wire        A_TO_B_OUT_ENABLE,
    input wire        B_TO_A_OUT_ENABLE_N,
    input wire        A_TO_B_LATCH_ENABLE,
    input wire        B_TO_A_LATCH_ENABLE,
    input wire        A_TO_B_CLOCK,
    input wire        B_TO_A_CLOCK,
    input wire [17:0] A_IN,
    input wire [17:0] A_DRIVEN,
    input wire [17:0] A_OUT,
    input wire [17:0] A_OE,
    input wire [17:0] B_IN,
    input wire [17:0] B_DRIVEN,
    input wire [17:0] B_OUT,
    input wire [17:0] B_OE
);
    logic [2:0] run_q;
    wire        ok = run_q == 3'h7;
    wire        lab = A_TO_B_LATCH_ENABLE;
    wire        lba = B_TO_A_LATCH_ENABLE;
    wire        cab = A_TO_B_CLOCK;
    wire        cba = B_TO_A_CLOCK;
    // Checks wait until the synchronisers hold only samples taken after reset.
    always @(posedge MCLK) begin
        if (!RST_N)
            run_q <= 3'h0;
        else if (!ok)
            run_q <= run_q + 3'h1;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_oe_ab: assert property (ok |-> B_OE == {18{$past(A_TO_B_OUT_ENABLE, 3)}})
        else $error("B enable lag wrong");
    a_oe_ba: assert property (ok |-> A_OE == {18{!$past(B_TO_A_OUT_ENABLE_N, 3)}})
        else $error("A enable lag wrong");
    a_flow_ab: assert property (ok && $past(lab, 3) && $past(&A_DRIVEN, 3) |-> B_OUT == $past(A_IN, 3))
        else $error("B not following A");
    a_flow_ba: assert property (ok && $past(lba, 3) && $past(&B_DRIVEN, 3) |-> A_OUT == $past(B_IN, 3))
        else $error("A not following B");
    a_edge_ab: assert property (ok && !$past(lab, 3) && $past(cab, 3) && !$past(cab, 4) && $past(&A_DRIVEN, 3)
        |-> B_OUT == $past(A_IN, 3))
        else $error("A to B edge not stored");
    a_edge_ba: assert property (ok && !$past(lba, 3) && $past(cba, 3) && !$past(cba, 4) && $past(&B_DRIVEN, 3)
        |-> A_OUT == $past(B_IN, 3))
        else $error("B to A edge not stored");
    a_hold_ab: assert property (ok && !$past(lab, 3) && $past(cab, 3) == $past(cab, 4) |-> $stable(B_OUT))
        else $error("B changed while held");
    a_hold_ba: assert property (ok && !$past(lba, 3) && $past(cba, 3) == $past(cba, 4) |-> $stable(A_OUT))
        else $error("A changed while held");
endmodule // brt_chk
bind brt_transceiver brt_chk u_chk (.*);

// file: testbench/brt_transceiver_bench.sv
// Self-checking bench for the 18-bit registered bus transceiver.
// Assumes brt_far_port drives both buses; an APB master task reaches the registers.
`timescale 1ns/1ps
`include "brt_defs.vh"
module brt_transceiver_bench;
    logic        mclk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, perr, e;
    logic        oe_ab = 1, oe_ba_n = 1, le_ab = 1, le_ba = 1, ck_ab = 0, ck_ba = 0, a_drv = 1, b_drv = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [17:0] a_val = 18'h0_0000, b_val = 18'h0_0000, a_pin, a_dn, a_out, a_oe, b_pin, b_dn, b_out, b_oe, ev, ew;
    integer      num_errors = 0, n_tests = 0;
    initial forever #4 mclk = ~mclk;
    brt_transceiver dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .A_TO_B_OUT_ENABLE(oe_ab),
        .B_TO_A_OUT_ENABLE_N(oe_ba_n), .A_TO_B_LATCH_ENABLE(le_ab), .B_TO_A_LATCH_ENABLE(le_ba),
        .A_TO_B_CLOCK(ck_ab), .B_TO_A_CLOCK(ck_ba), .A_IN(a_pin), .A_DRIVEN(a_dn), .A_OUT(a_out), .A_OE(a_oe),
        .B_IN(b_pin), .B_DRIVEN(b_dn), .B_OUT(b_out), .B_OE(b_oe));
    brt_far_port far_a (.clk(mclk), .drive(a_drv), .val(a_val), .dev_out(a_out), .dev_oe(a_oe), .pin(a_pin),
        .driven(a_dn));
    brt_far_port far_b (.clk(mclk), .drive(b_drv), .val(b_val), .dev_out(b_out), .dev_oe(b_oe), .pin(b_pin),
        .driven(b_dn));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
        @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hFC2ADA96));
        cyc(6);
        rst_n <= 1;
        cyc(6);
        chk("a_oe", 18'h0_0000, a_oe);
        for (int i = 0; i < 3; i++) begin
            a_val <= 18'($urandom);
            cyc(5);
            chk("b_pin", a_val, b_pin);
        end
        $display("test transparent done");
        le_ab <= 0;
        cyc(5);
        ev = a_val;
        a_val <= ~a_val;
        cyc(5);
        chk("b_pin", ev, b_pin);
        ck_ab <= 1;
        cyc(5);
        chk("b_pin", a_val, b_pin);
        le_ab <= 1;
        cyc(5);
        le_ab <= 0;
        cyc(5);
        ev = a_val;
        a_val <= 18'($urandom);
        cyc(5);
        chk("b_pin", ev, b_pin);
        $display("test clocked done");
        oe_ab <= 0;
        oe_ba_n <= 0;
        a_drv <= 0;
        b_drv <= 1;
        b_val <= 18'($urandom);
        cyc(5);
        chk("b_oe", 18'h0_0000, b_oe);
        chk("a_pin", b_val, a_pin);
        le_ba <= 0;
        cyc(5);
        ew = b_val;
        b_val <= ~b_val;
        cyc(5);
        chk("a_pin", ew, a_pin);
        ck_ba <= 1;
        cyc(5);
        chk("a_pin", b_val, a_pin);
        le_ba <= 1;
        apb(1, `BRT_ADDR_CTRL, 32'h0000_0002);
        ew = b_val;
        b_drv <= 0;
        cyc(5);
        chk("a_pin", ew, a_pin);
        $display("test reverse done");
        apb(0, `BRT_ADDR_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0002, r);
        apb(0, `BRT_ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_002B, r);
        apb(0, `BRT_ADDR_DATA_AB, 32'h0000_0000);
        chk("data_ab", {14'h0000, ev}, r);
        apb(0, `BRT_ADDR_DATA_BA, 32'h0000_0000);
        chk("data_ba", {14'h0000, ew}, r);
        apb(0, 12'h010, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, e});
        chk("prdata", 32'h0000_0000, r);
        $display("test registers done");
        apb(1, `BRT_ADDR_CTRL, 32'h0000_0001);
        oe_ab <= 1;
        oe_ba_n <= 1;
        le_ab <= 1;
        a_drv <= 1;
        a_val <= 18'($urandom);
        cyc(5);
        ev = a_val;
        chk("b_pin", ev, b_pin);
        a_drv <= 0;
        cyc(5);
        chk("b_pin", ev, b_pin);
        $display("test hold A done");
        rst_n <= 0;
        cyc(2);
        rst_n <= 1;
        apb(0, `BRT_ADDR_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0000, r);
        $display("test reset done");
        complete_run;
    end
    initial begin
        cyc(3000);
        num_errors++;
        complete_run;
    end
endmodule // brt_transceiver_bench
